// ### rtl/flash_status_register_logic.sv
// Purpose: Status and configuration registers of a serial NOR flash
// Assumes: Commands arrive already decoded on the serial clock domain
// Notes: Register state lives on core_clk_i; the link sees snapshots
`timescale 1ns/100ps
`include "flash_sr_defs.svh"

// Summary of operation
// RULE1: Config bit seven picks hold or reset role
// RULE2: Pin role only active while quad off
// RULE3: Config bits six,five set read drive strength
// RULE4: Config bit four enables high frequency mode
// RULE5: Host ignores reserved bits when reading
// RULE6: Busy set during program, erase, status write
// RULE7: While busy only status reads accepted; the code also takes suspend while an array operation is busy
// RULE8: Busy clears when the operation finishes
// RULE9: Write enable command sets write enable latch
// RULE10: Latch clears on disable, program, erase, write
// RULE11: Protect level field, writable, default zero
// RULE12: Top/bottom bit picks protected region origin
// RULE13: Granularity bit picks sectors or blocks
// RULE14: Complement bit swaps protected and unprotected
// RULE15: Protect mode with write-protect pin locks
// RULE16: Status writes never touch busy, latch, suspend
// RULE17: Write enable then status write: non-volatile
// RULE18: Volatile enable then status write: volatile only
// RULE19: Locked state rejects all configurable bits
// RULE20: Lock bits untouched by volatile writes
// RULE21: Suspend sets flag, resume clears it
// RULE22: One-time lock bits, set individually, permanent
// RULE23: Quad enable turns pins into data lines
// RULE24: Drive code maps to 50,25,75,100 percent
// RULE25: Host sends write enable before writes
module flash_status_register_logic
	import flash_sr_pkg::*;
#(
	parameter int unsigned WRSR_CYCLES = `WRSR_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	input wire logic link_rstn_i,
	input wire logic cmd_valid_i,
	input wire cmd_t cmd_i,
	output logic cmd_ready_o,
	output status_t status_o,
	input wire logic wp_n_i,
	input wire logic soft_reset_i,
	input wire logic array_done_i,
	output logic array_start_o,
	output logic [7:0] array_opcode_o,
	output logic suspended_o,
	output protect_cfg_t protect_cfg_o,
	output logic hold_fn_en_o,
	output logic hwreset_fn_en_o,
	output logic wp_fn_en_o,
	output logic quad_enable_o,
	output logic [1:0] drive_strength_o,
	output logic [6:0] drive_pct_o,
	output logic high_freq_mode_enable_o
);

	core_state_t state_q;
	logic [31:0] timer_q;
	logic write_enable_latch_q, vol_wren_q;
	logic [7:0] nv_one_q, nv_two_q, nv_three_q;
	logic [7:0] vol_one_q, vol_two_q, vol_three_q;
	logic suspend_flag_q;
	status_t sent_q;
	logic wp_n_s, cmd_go, stat_ready, stat_push;
	cmd_t cmd_c;
	logic [$bits(cmd_t)-1:0] cmd_bits;
	logic [$bits(status_t)-1:0] stat_bits;
	logic busy, exec, is_wrsr, is_prog, locked, wr_ok, nv_wr, vol_wr;
	logic [7:0] new_one, new_two, new_three;
	logic [7:0] mask_one, mask_two, mask_three;
	status_t image;

	// Keep unmasked bits, take masked bits from the new byte
	function automatic logic [7:0] merge(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// Drive code to percent of full strength
	function automatic logic [6:0] drv_pct(input logic [1:0] code);
		case (code)
			2'b00: drv_pct = `DRV_PCT_00;
			2'b01: drv_pct = `DRV_PCT_01;
			2'b10: drv_pct = `DRV_PCT_10;
			default: drv_pct = `DRV_PCT_11;
		endcase
	endfunction

	// Program and erase opcodes that need the latch
	function automatic logic is_array_op(input logic [7:0] op);
		is_array_op = (op == `OP_PAGE_PROG) || (op == `OP_SECT_ERASE) ||
			(op == `OP_BLK32_ERASE) || (op == `OP_BLK64_ERASE) ||
			(op == `OP_CHIP_ERASE_A) || (op == `OP_CHIP_ERASE_B);
	endfunction

	// Commands cross from the serial clock one at a time
	word_xfer #(
		.W($bits(cmd_t))
	) u_cmd_xfer (
		.src_clk_i(sclk_i),
		.src_rstn_i(link_rstn_i),
		.src_valid_i(cmd_valid_i),
		.src_data_i(cmd_i),
		.src_ready_o(cmd_ready_o),
		.dst_clk_i(core_clk_i),
		.dst_rstn_i(rstn_i),
		.dst_valid_o(cmd_go),
		.dst_data_o(cmd_bits)
	);

	assign cmd_c = cmd_t'(cmd_bits);

	// Status image goes back whenever it differs from the last one sent
	word_xfer #(
		.W($bits(status_t))
	) u_stat_xfer (
		.src_clk_i(core_clk_i),
		.src_rstn_i(rstn_i),
		.src_valid_i(stat_push),
		.src_data_i(image),
		.src_ready_o(stat_ready),
		.dst_clk_i(sclk_i),
		.dst_rstn_i(link_rstn_i),
		.dst_valid_o(),
		.dst_data_o(stat_bits)
	);

	// Serial clock may stop between frames; last image is simply held
	assign status_o = status_t'(stat_bits);

	// Write-protect pin arrives from outside
	bit_sync3 u_wp_sync (
		.clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.async_i(wp_n_i),
		.sync_o(wp_n_s)
	);

	// Busy covers non-volatile status writes and array operations
	assign busy = (state_q == ST_WRSR_BUSY) ||
		(state_q == ST_ARRAY_BUSY); // see RULE6

	// Only suspend gets through a busy array; reads never reach here
	assign exec = cmd_go && (!busy || ((state_q == ST_ARRAY_BUSY) &&
		(cmd_c.opcode == `OP_SUSPEND))); // see RULE7

	assign is_wrsr = exec && ((cmd_c.opcode == `OP_WRSR1) ||
		(cmd_c.opcode == `OP_WRSR2) || (cmd_c.opcode == `OP_WRSR3));

	// No new array operation while one is suspended
	assign is_prog = exec && is_array_op(cmd_c.opcode) &&
		write_enable_latch_q && !suspend_flag_q; // see RULE25

	// Pin only protects while the quad lines are off
	assign locked = vol_one_q[`SR1_PMODE] && !wp_n_s &&
		!vol_two_q[`SR2_QE]; // see RULE15
	assign wr_ok = !locked && (write_enable_latch_q || vol_wren_q);
	assign nv_wr = is_wrsr && wr_ok && write_enable_latch_q &&
		!suspend_flag_q; // see RULE17 see RULE6
	assign vol_wr = is_wrsr && wr_ok && !write_enable_latch_q &&
		vol_wren_q; // see RULE18

	// Route data bytes to target registers by opcode and length
	always_comb begin
		new_one = cmd_c.data0;
		new_two = cmd_c.data0;
		new_three = cmd_c.data0;
		mask_one = 8'h00;
		mask_two = 8'h00;
		mask_three = 8'h00;
		case (cmd_c.opcode)
			`OP_WRSR1: begin
				mask_one = `SR1_CFG_MASK;
				new_two = cmd_c.data1;
				if (cmd_c.nbytes == 2'h2) begin
					mask_two = `SR2_CFG_MASK;
				end
			end
			`OP_WRSR2: begin
				mask_two = `SR2_CFG_MASK;
			end
			`OP_WRSR3: begin
				mask_three = `SR3_CFG_MASK;
			end
			default: mask_one = 8'h00;
		endcase
	end

	// Sequencer and write timer
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || soft_reset_i) begin
			state_q <= ST_IDLE;
			timer_q <= 32'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (nv_wr) begin
						state_q <= ST_WRSR_BUSY;
						timer_q <= 32'(WRSR_CYCLES);
					end else if (is_prog) begin
						state_q <= ST_ARRAY_BUSY;
					end
				end
				ST_WRSR_BUSY: begin
					if (timer_q <= 32'h1) begin
						state_q <= ST_IDLE; // see RULE8
					end else begin
						timer_q <= timer_q - 32'h1;
					end
				end
				ST_ARRAY_BUSY: begin
					if (array_done_i) begin
						state_q <= ST_IDLE; // see RULE8
					end else if (exec) begin
						state_q <= ST_SUSPENDED;
					end
				end
				ST_SUSPENDED: begin
					if (exec && cmd_c.opcode == `OP_RESUME) begin
						state_q <= ST_ARRAY_BUSY;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Write enable latch
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || soft_reset_i) begin
			write_enable_latch_q <= 1'b0; // see RULE10
		end else if (exec && cmd_c.opcode == `OP_WREN) begin
			write_enable_latch_q <= 1'b1; // see RULE9
		end else if (is_wrsr || is_prog ||
			(exec && cmd_c.opcode == `OP_WRDI)) begin
			write_enable_latch_q <= 1'b0; // see RULE10
		end
	end

	// Volatile enable lasts only to the very next command
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || soft_reset_i) begin
			vol_wren_q <= 1'b0;
		end else if (exec) begin
			vol_wren_q <= (cmd_c.opcode == `OP_VWREN);
		end
	end

	// Non-volatile copies; only the power cycle model clears them
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			nv_one_q <= `SR_RESET_VAL; // see RULE11
			nv_two_q <= `SR_RESET_VAL; // see RULE22
			nv_three_q <= `SR_RESET_VAL;
		end else if (nv_wr) begin
			nv_one_q <= merge(nv_one_q, new_one, mask_one); // see RULE19
			// Lock bits only ever set, each on its own
			nv_two_q <= merge(nv_two_q, new_two, mask_two) |
				(new_two & {8{mask_two != 8'h00}} &
				`SR2_LOCK_MASK); // see RULE22
			nv_three_q <= merge(nv_three_q, new_three, mask_three);
		end
	end

	// Volatile copies steer the device; reloaded on soft reset
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			vol_one_q <= `SR_RESET_VAL;
			vol_two_q <= `SR_RESET_VAL;
			vol_three_q <= `SR_RESET_VAL;
		end else if (soft_reset_i) begin
			vol_one_q <= nv_one_q;
			vol_two_q <= nv_two_q & ~`SR2_LOCK_MASK;
			vol_three_q <= nv_three_q;
		end else if (nv_wr || vol_wr) begin
			// Lock bits are never held here, so volatile writes skip them
			vol_one_q <= merge(vol_one_q, new_one, mask_one);
			vol_two_q <= merge(vol_two_q, new_two, mask_two); // see RULE20
			vol_three_q <= merge(vol_three_q, new_three, mask_three);
		end
	end

	// Suspend flag; status writes have no path to it
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || soft_reset_i) begin
			suspend_flag_q <= 1'b0;
		end else if (state_q == ST_ARRAY_BUSY && exec &&
			cmd_c.opcode == `OP_SUSPEND) begin
			suspend_flag_q <= 1'b1; // see RULE21
		end else if (state_q == ST_SUSPENDED && exec &&
			cmd_c.opcode == `OP_RESUME) begin
			suspend_flag_q <= 1'b0; // see RULE21
		end
	end

	// Read image; reserved bits read zero, host treats them as don't care
	always_comb begin
		image.reg_one = (vol_one_q & `SR1_CFG_MASK) |
			{6'h00, write_enable_latch_q, busy}; // see RULE16
		image.reg_two = (vol_two_q & `SR2_CFG_MASK) |
			(nv_two_q & `SR2_LOCK_MASK) |
			{suspend_flag_q, 7'h00}; // see RULE16
		image.reg_three = vol_three_q & `SR3_CFG_MASK; // see RULE5
	end

	// Push a new image only when it changed and the crossing is free
	assign stat_push = stat_ready && (image != sent_q);

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			sent_q <= '0;
		end else if (stat_push) begin
			sent_q <= image;
		end
	end

	// Array start pulse and opcode for the program/erase engine
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || soft_reset_i) begin
			array_start_o <= 1'b0;
			array_opcode_o <= 8'h00;
		end else begin
			array_start_o <= is_prog && (state_q == ST_IDLE);
			if (is_prog && (state_q == ST_IDLE)) begin
				array_opcode_o <= cmd_c.opcode;
			end
		end
	end

	// Effective configuration taken from the volatile copies
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			protect_cfg_o <= '0;
			hold_fn_en_o <= 1'b0;
			hwreset_fn_en_o <= 1'b0;
			wp_fn_en_o <= 1'b0;
			quad_enable_o <= 1'b0;
			drive_strength_o <= 2'h0;
			drive_pct_o <= 7'h00;
			high_freq_mode_enable_o <= 1'b0;
			suspended_o <= 1'b0;
		end else begin
			protect_cfg_o <= {vol_two_q[`SR2_CMP], // see RULE14
				vol_one_q[`SR1_GRAN], // see RULE13
				vol_one_q[`SR1_TB], // see RULE12
				vol_one_q[`SR1_BP_LSB +: 3]}; // see RULE11
			hold_fn_en_o <= !vol_three_q[`SR3_ROLE] &&
				!vol_two_q[`SR2_QE]; // see RULE1 see RULE2
			hwreset_fn_en_o <= vol_three_q[`SR3_ROLE] &&
				!vol_two_q[`SR2_QE]; // see RULE1 see RULE2
			wp_fn_en_o <= !vol_two_q[`SR2_QE]; // see RULE23
			quad_enable_o <= vol_two_q[`SR2_QE]; // see RULE23
			drive_strength_o <= vol_three_q[`SR3_DRV_LSB +: 2]; // see RULE3
			drive_pct_o <= drv_pct(vol_three_q[`SR3_DRV_LSB +: 2]); // see RULE24
			high_freq_mode_enable_o <= vol_three_q[`SR3_HFQ]; // see RULE4
			suspended_o <= suspend_flag_q;
		end
	end

endmodule // flash_status_register_logic

// ### rtl/flash_sr_defs.svh
// Purpose: Offsets, field positions, opcodes and timing of the status block
// Assumes: Included by the package and by the status register module
// Notes: Definitions only
`ifndef FLASH_SR_DEFS_SVH
`define FLASH_SR_DEFS_SVH

// Opcodes seen on the serial link
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_VWREN 8'h50
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_PAGE_PROG 8'h02
`define OP_SECT_ERASE 8'h20
`define OP_BLK32_ERASE 8'h52
`define OP_BLK64_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'hC7
`define OP_CHIP_ERASE_B 8'h60

// Field positions, register one
`define SR1_BUSY 0
`define SR1_WEL 1
`define SR1_BP_LSB 2
`define SR1_TB 5
`define SR1_GRAN 6
`define SR1_PMODE 7
// Field positions, register two
`define SR2_QE 1
`define SR2_LB_LSB 3
`define SR2_CMP 6
`define SR2_SUS 7
// Field positions, register three
`define SR3_HFQ 4
`define SR3_DRV_LSB 5
`define SR3_ROLE 7

// Writable masks and factory defaults
`define SR1_CFG_MASK 8'hFC
`define SR2_CFG_MASK 8'h42
`define SR2_LOCK_MASK 8'h38
`define SR3_CFG_MASK 8'hF0
`define SR_RESET_VAL 8'h00

// Drive strength in percent per code
`define DRV_PCT_00 7'h32
`define DRV_PCT_01 7'h19
`define DRV_PCT_10 7'h4B
`define DRV_PCT_11 7'h64

// Non-volatile status write time and core clock period
`define WRSR_TIME_NS 5000000
`define CORE_CLK_PERIOD_NS 20
`define WRSR_CYCLES (`WRSR_TIME_NS / `CORE_CLK_PERIOD_NS)

`endif

// ### rtl/flash_sr_pkg.sv
// Purpose: Types shared by the status block and its crossings
// Assumes: Constants come from the defs header
// Notes: Types only
`include "flash_sr_defs.svh"

package flash_sr_pkg;

	// One decoded command with up to two data bytes
	typedef struct packed {
		logic [7:0] opcode;
		logic [1:0] nbytes;
		logic [7:0] data0;
		logic [7:0] data1;
	} cmd_t;

	// Read image of all three status bytes
	typedef struct packed {
		logic [7:0] reg_three;
		logic [7:0] reg_two;
		logic [7:0] reg_one;
	} status_t;

	// Effective protection settings handed to the array guard
	typedef struct packed {
		logic protect_complement;
		logic protect_granularity;
		logic top_bottom_select;
		logic [2:0] protect_level;
	} protect_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRSR_BUSY,
		ST_ARRAY_BUSY,
		ST_SUSPENDED
	} core_state_t;

endpackage

// ### rtl/bit_sync3.sv
// Purpose: Three stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes: A change is taken once stages two and three agree
`timescale 1ns/100ps

module bit_sync3 (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic async_i,
	output logic sync_o
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Stage one is read only by stage two
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Hold the old level until two later stages agree
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sync_o <= 1'b0;
		end else if (s2_q == s3_q) begin
			sync_o <= s3_q;
		end
	end

endmodule // bit_sync3

// ### rtl/word_xfer.sv
// Purpose: Toggle handshake carrying one word between two clocks
// Assumes: Source holds nothing; the word is latched on accept
// Notes: One word in flight; src_ready_o drops until it is acknowledged
`timescale 1ns/100ps

module word_xfer #(
	parameter int W = 8
) (
	input wire logic src_clk_i,
	input wire logic src_rstn_i,
	input wire logic src_valid_i,
	input wire logic [W-1:0] src_data_i,
	output logic src_ready_o,
	input wire logic dst_clk_i,
	input wire logic dst_rstn_i,
	output logic dst_valid_o,
	output logic [W-1:0] dst_data_o
);

	logic req_q;
	logic ack_q;
	logic req_s;
	logic ack_s;
	logic [W-1:0] hold_q;

	// Word stays frozen while the request toggle is outstanding
	assign src_ready_o = (req_q == ack_s);

	always_ff @(posedge src_clk_i) begin
		if (!src_rstn_i) begin
			req_q <= 1'b0;
			hold_q <= '0;
		end else if (src_valid_i && src_ready_o) begin
			req_q <= ~req_q;
			hold_q <= src_data_i;
		end
	end

	bit_sync3 u_req_sync (
		.clk_i(dst_clk_i),
		.rstn_i(dst_rstn_i),
		.async_i(req_q),
		.sync_o(req_s)
	);

	// Capture on a new toggle, then echo it back as the acknowledge
	always_ff @(posedge dst_clk_i) begin
		if (!dst_rstn_i) begin
			ack_q <= 1'b0;
			dst_valid_o <= 1'b0;
			dst_data_o <= '0;
		end else begin
			dst_valid_o <= (req_s != ack_q);
			if (req_s != ack_q) begin
				ack_q <= req_s;
				dst_data_o <= hold_q;
			end
		end
	end

	bit_sync3 u_ack_sync (
		.clk_i(src_clk_i),
		.rstn_i(src_rstn_i),
		.async_i(ack_q),
		.sync_o(ack_s)
	);

endmodule // word_xfer

// ### test/flash_sr_properties.sv
// Purpose: Port properties of the status register block
// Assumes: Bound to the block; core and link domains checked apart
// Notes: Start and done pulses keep a busy shadow
`timescale 1ns/100ps

module flash_sr_properties
	import flash_sr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	input wire logic link_rstn_i,
	input wire status_t status_o,
	input wire logic soft_reset_i,
	input wire logic array_done_i,
	input wire logic array_start_o,
	input wire logic [7:0] array_opcode_o,
	input wire logic suspended_o,
	input wire logic hold_fn_en_o,
	input wire logic hwreset_fn_en_o,
	input wire logic wp_fn_en_o,
	input wire logic quad_enable_o,
	input wire logic [1:0] drive_strength_o,
	input wire logic [6:0] drive_pct_o
);
	logic arr_busy_q;
	logic [6:0] pct_exp;

	// Shadow of the array engine, set by start and cleared by done
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || soft_reset_i)
			arr_busy_q <= 1'b0;
		else if (array_start_o)
			arr_busy_q <= 1'b1;
		else if (array_done_i)
			arr_busy_q <= 1'b0;
	end

	// Own percent table, so a slip in the block's table shows
	assign pct_exp = drive_strength_o[1] ? (drive_strength_o[0] ? 7'h64 :
		7'h4B) : (drive_strength_o[0] ? 7'h19 : 7'h32);

	sequence s_pulse;
		array_start_o ##1 !array_start_o;
	endsequence
	property p_start_pulse;
		@(posedge core_clk_i) disable iff (!rstn_i) array_start_o |-> s_pulse;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("array start wider than one cycle");
	property p_start_op;
		@(posedge core_clk_i) disable iff (!rstn_i) array_start_o |->
			array_opcode_o inside {8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
	endproperty
	a_start_op: assert property (p_start_op)
		else $error("array start with a foreign opcode");
	property p_no_start_busy;
		@(posedge core_clk_i) disable iff (!rstn_i)
			array_start_o |-> !arr_busy_q;
	endproperty
	a_no_start_busy: assert property (p_no_start_busy)
		else $error("array start while busy");
	property p_susp_busy;
		@(posedge core_clk_i) disable iff (!rstn_i)
			$rose(suspended_o) |-> arr_busy_q;
	endproperty
	a_susp_busy: assert property (p_susp_busy)
		else $error("suspend raised with no array work");
	property p_roles;
		@(posedge core_clk_i) disable iff (!rstn_i)
			(hold_fn_en_o || hwreset_fn_en_o) |->
			!quad_enable_o && (hold_fn_en_o ^ hwreset_fn_en_o);
	endproperty
	a_roles: assert property (p_roles)
		else $error("pin role shown with quad on or both roles");
	property p_wp_fn;
		@(posedge core_clk_i) disable iff (!rstn_i)
			$past(rstn_i) |-> wp_fn_en_o == !quad_enable_o;
	endproperty
	a_wp_fn: assert property (p_wp_fn)
		else $error("protect pin function disagrees with quad");
	property p_drive;
		@(posedge core_clk_i) disable iff (!rstn_i)
			$past(rstn_i) |-> drive_pct_o == pct_exp;
	endproperty
	a_drive: assert property (p_drive)
		else $error("drive percent does not match code");
	property p_reserved;
		@(posedge sclk_i) disable iff (!link_rstn_i)
			status_o.reg_three[3:0] == 4'h0 && !status_o.reg_two[2] &&
			!status_o.reg_two[0];
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bit not zero");
endmodule // flash_sr_properties

bind flash_status_register_logic flash_sr_properties u_props (.core_clk_i,
	.rstn_i, .sclk_i, .link_rstn_i, .status_o, .soft_reset_i, .array_done_i,
	.array_start_o, .array_opcode_o, .suspended_o, .hold_fn_en_o,
	.hwreset_fn_en_o, .wp_fn_en_o, .quad_enable_o, .drive_strength_o,
	.drive_pct_o);

// ### test/host_model.sv
// Purpose: Host side of the decoded command link
// Assumes: Commands change after a falling link clock edge
// Notes: A released command bus shows the inverted last word
`timescale 1ns/100ps

module host_model
	import flash_sr_pkg::*;
(
	input wire logic sclk_i,
	input wire logic ready_i,
	output logic cmd_valid_o,
	output cmd_t cmd_o
);
	int n_to = 0;

	// Idle bus at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
	end

	// Hold the command until ready is seen high at a rising edge
	task automatic send(input logic [7:0] op, input logic [1:0] n,
		input logic [7:0] d0, input logic [7:0] d1);
		int i = 0;
		@(negedge sclk_i);
		cmd_o = {op, n, d0, d1};
		cmd_valid_o = 1'b1;
		do begin
			@(posedge sclk_i);
			i++;
		end while (ready_i !== 1'b1 && i < 64);
		if (i >= 64)
			n_to++;
		@(negedge sclk_i);
		cmd_valid_o = 1'b0;
		cmd_o = ~cmd_o;
	endtask
endmodule // host_model

// ### test/testbench.sv
// Purpose: Self-checking bench for the status register block
// Assumes: Link clock runs free so status snapshots keep flowing
// Notes: A short status write timer keeps the run brief
`timescale 1ns/100ps

module testbench import flash_sr_pkg::*;;
	logic clk = 1'b0;
	logic sclk = 1'b0;
	logic rstn, lrstn, wpn, srst, done, cv, rdy, start, susp, qe, high_freq_mode_enable;
	logic hold, hwr, wpf;
	logic [1:0] drv;
	logic [6:0] pct_o;
	logic [7:0] aop, last_op, d0, d1;
	logic [7:0] aops [6] = '{8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
	logic [7:0] lbw [3] = '{8'h08, 8'h20, 8'h00};
	logic [7:0] lbx [3] = '{8'h08, 8'h28, 8'h28};
	cmd_t cmd;
	status_t st;
	protect_cfg_t pc;
	int n_fail = 0;
	int n_tests = 0;
	int n_start = 0;
	int k;

	// Core clock 20 ns; link clock 125 ns on an offset phase
	always #10 clk = ~clk;
	initial begin
		#3.3;
		forever #62.5 sclk = ~sclk;
	end

	flash_status_register_logic #(.WRSR_CYCLES(100)) u_dut (
		.core_clk_i(clk), .rstn_i(rstn), .sclk_i(sclk),
		.link_rstn_i(lrstn), .cmd_valid_i(cv), .cmd_i(cmd),
		.cmd_ready_o(rdy), .status_o(st), .wp_n_i(wpn),
		.soft_reset_i(srst), .array_done_i(done),
		.array_start_o(start), .array_opcode_o(aop),
		.suspended_o(susp), .protect_cfg_o(pc), .hold_fn_en_o(hold),
		.hwreset_fn_en_o(hwr), .wp_fn_en_o(wpf), .quad_enable_o(qe),
		.drive_strength_o(drv), .drive_pct_o(pct_o),
		.high_freq_mode_enable_o(high_freq_mode_enable));
	host_model u_host (.sclk_i(sclk), .ready_i(rdy), .cmd_valid_o(cv),
		.cmd_o(cmd));

	// Count start pulses at the falling edge, where the pulse has settled
	always @(negedge clk) begin
		if (start === 1'b1) begin
			n_start++;
			last_op = aop;
		end
	end

	function automatic logic [6:0] pct(input logic [1:0] c);
		return c[1] ? (c[0] ? 7'h64 : 7'h4B) : (c[0] ? 7'h19 : 7'h32);
	endfunction
	// Expected {hold, reset, protect pin} functions
	function automatic logic [2:0] roles(input logic [7:0] r3, input logic q);
		return q ? 3'h0 : {~r3[7], r3[7], 1'b1};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		n_fail += u_host.n_to;
		$display("tests=%0d failures=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge sclk);
	endtask
	// One command, then time for both crossings
	task automatic go(input logic [7:0] op, input logic [7:0] a = 8'h00,
		input logic [7:0] b = 8'h00, input logic [1:0] n = 2'h1);
		u_host.send(op, n, a, b);
		if (u_host.n_to != 0)
			tally_and_finish();
		settle(24);
	endtask
	task automatic wait_bit(input int b, input logic v);
		int i;
		for (i = 0; i < 64 && st[b] !== v; i++)
			@(negedge sclk);
		chk(st[b], v);
		if (i >= 64)
			tally_and_finish();
	endtask
	// Write enable, status write, and the busy window it opens
	task automatic nvw(input logic [7:0] op, input logic [7:0] a,
		input logic [7:0] b = 8'h00, input logic [1:0] n = 2'h1);
		go(8'h06);
		u_host.send(op, n, a, b);
		wait_bit(0, 1'b1);
		wait_bit(0, 1'b0);
		settle(4);
	endtask
	task automatic setwp(input logic v);
		@(negedge clk) wpn = v;
		settle(8);
	endtask

	initial begin
		rstn = 1'b0;
		lrstn = 1'b0;
		wpn = 1'b1;
		srst = 1'b0;
		done = 1'b0;
		void'($urandom(61));
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (5) @(negedge sclk);
		lrstn = 1'b1;
		settle(8);
		chk(st, 24'h0);
		chk(pct_o, 7'h32);
		chk({hold, hwr, wpf}, 3'h5);
		go(8'h06);
		chk(st.reg_one[1], 1'b1);
		go(8'h04);
		chk(st.reg_one[1], 1'b0);
		// Random stored writes; read-only flag bits offered as ones
		for (k = 0; k < 3; k++) begin
			d0 = 8'($urandom) & 8'h7F | 8'h03;
			d1 = 8'($urandom) & 8'hC7 | 8'h81;
			nvw(8'h01, d0, d1, 2'h2);
			chk(st.reg_one, d0 & 8'hFC);
			chk(st.reg_two, d1 & 8'h42);
			chk(pc, {d1[6], d0[6:2]});
			chk(qe, d1[1]);
		end
		// Volatile config sweep over both roles and all drive codes
		go(8'h50);
		go(8'h31, 8'h00);
		for (k = 0; k < 8; k++) begin
			d0 = {k[2:0], 5'($urandom)};
			go(8'h50);
			go(8'h11, d0);
			chk(st.reg_three, d0 & 8'hF0);
			chk(drv, d0[6:5]);
			chk(pct_o, pct(d0[6:5]));
			chk(high_freq_mode_enable, d0[4]);
			chk({hold, hwr, wpf}, roles(d0, 1'b0));
		end
		go(8'h50);
		go(8'h31, 8'h3A);
		chk(st.reg_two, 8'h02);
		chk({hold, hwr, wpf}, 3'h0);
		// Soft reset brings back the stored copies
		@(negedge clk) srst = 1'b1;
		@(negedge clk) srst = 1'b0;
		settle(24);
		chk(st.reg_three, 8'h00);
		chk(st.reg_two, d1 & 8'h42);
		for (k = 0; k < 3; k++) begin
			nvw(8'h31, lbw[k]);
			chk(st.reg_two, lbx[k]);
		end
		// Array work with no enable is dropped
		go(8'h02);
		chk(n_start, 0);
		for (k = 0; k < 6; k++) begin
			go(8'h06);
			u_host.send(aops[k], 2'h0, 8'h00, 8'h00);
			wait_bit(0, 1'b1);
			chk(last_op, aops[k]);
			chk(st.reg_one[1], 1'b0);
			if (k == 0) begin
				go(8'h06);
				chk(st.reg_one[1], 1'b0);
				go(8'h75);
				chk({st.reg_two[7], susp}, 2'h3);
				go(8'h7A);
				chk({st.reg_two[7], st.reg_one[0]}, 2'h1);
			end
			@(negedge clk) done = 1'b1;
			@(negedge clk) done = 1'b0;
			wait_bit(0, 1'b0);
		end
		chk(n_start, 6);
		// Protect mode with the pin low locks; pin high or mode off frees
		nvw(8'h01, 8'h80);
		setwp(1'b0);
		go(8'h06);
		go(8'h01, 8'h9C);
		chk(st.reg_one, 8'h80);
		go(8'h06);
		go(8'h11, 8'hF0);
		chk(st.reg_three, 8'h00);
		setwp(1'b1);
		nvw(8'h01, 8'h04);
		chk(st.reg_one, 8'h04);
		setwp(1'b0);
		nvw(8'h01, 8'h1C);
		chk(st.reg_one, 8'h1C);
		// Stored write of the config byte: reset role, quarter drive
		nvw(8'h11, 8'hA0);
		chk(st.reg_three, 8'hA0);
		chk({drv, pct_o}, {2'h1, pct(2'h1)});
		chk({hold, hwr, wpf}, roles(8'hA0, 1'b0));
		tally_and_finish();
	end
endmodule // testbench
